// ---- hdl/shsr_map.svh ----
// register map, field positions and timing figures of the
// sector header/status register bank.
// assumes AXI4-Lite byte addresses: index times four.
`ifndef SHSR_MAP_SVH
`define SHSR_MAP_SVH
`define SHSR_AW 7
`define SHSR_IDX_RAWMODE 5'h03
`define SHSR_IDX_BLK 5'h06
`define SHSR_IDX_MODE 5'h07
`define SHSR_IDX_FILE 5'h08
`define SHSR_IDX_CHAN 5'h09
`define SHSR_IDX_SUBM 5'h0a
`define SHSR_IDX_DTYP 5'h0b
`define SHSR_IDX_RAWFLG 5'h0c
`define SHSR_IDX_BFFLG 5'h0d
`define SHSR_IDX_STS0 5'h0e
`define SHSR_IDX_STS1 5'h0f
`define SHSR_IDX_LAST_H 5'h10
`define SHSR_IDX_LAST_L 5'h11
`define SHSR_IDX_AUX 5'h18
`define SHSR_IDX_TGT_MIN 5'h19
`define SHSR_IDX_TGT_SEC 5'h1a
`define SHSR_IDX_TGT_BLK 5'h1b
`define SHSR_AUX_AUTO 0
`define SHSR_AUX_MBH 1
`define SHSR_AUX_SHSEL 2
`define SHSR_AUX_REC 7
`define SHSR_DET_EN 0
`define SHSR_SHORT_LEN 12'h92f
`define SHSR_MODE1 8'h01
`define SHSR_MODE2 8'h02
`define SHSR_RESP_OKAY 2'h0
`define SHSR_RESP_SLVERR 2'h2
`define SHSR_RST_BYTE 8'h00
`endif

// ---- hdl/shsr_pkg.sv ----
// types shared by the sector header/status register bank.
// assumes the decoder core hands over one sector record per
// decoder interrupt.
package shsr_pkg;
  typedef enum logic [2:0] {
    SHSR_DISABLED,
    SHSR_MONITOR,
    SHSR_WRITE_ONLY,
    SHSR_REAL_TIME,
    SHSR_REPEAT,
    SHSR_ASYNC
  } shsr_dec_mode_t;

  // byte order inside 32-bit groups: file, chan, submode, dtype
  typedef struct packed {
    logic [7:0] hdr_min;
    logic [7:0] hdr_sec;
    logic [7:0] hdr_blk;
    logic [7:0] hdr_mode;
    logic [3:0] hdr_ptr;
    logic [31:0] sh_a;
    logic [31:0] sh_b;
    logic [3:0] sh_ptr_a;
    logic [3:0] sh_ptr_b;
    logic [7:0] raw_mode;
    logic [3:0] raw_ptr;
    logic [11:0] sync_gap;
    logic sync_ins;
    logic any_ptr;
    logic corrected;
    logic edc_fail;
    logic ecc_fail;
    logic [31:0] parity;
    logic [3:0] parity_ptr;
    logic discriminated_mode_bit;
    logic discriminated_form_bit;
  } shsr_sector_t;
endpackage : shsr_pkg

// ---- hdl/shsr_regs.sv ----
// sector header/status register bank with AXI4-Lite slave.
// assumes sector records arrive with a one-cycle decoder
// interrupt pulse, all on aclk.
`timescale 1ns/1ps
`include "shsr_map.svh"

module shsr_regs
  import shsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic decoder_interrupt,
  input wire shsr_dec_mode_t dec_mode,
  input wire shsr_sector_t sector,
  output logic correction_inhibit_flag,
  output logic short_sector_flag,
  output logic recordable_disc_status,
  output logic [8:0] last_area,
  input wire logic [`SHSR_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SHSR_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // stored state
  logic [7:0] raw_mode_reg;
  logic [3:0] raw_ptr_reg;
  logic [7:0] blk_reg;
  logic [7:0] mode_reg;
  logic [7:0] file_reg;
  logic [7:0] chan_reg;
  logic [7:0] subm_reg;
  logic [7:0] dtyp_reg;
  logic [7:0] bfflg_reg;
  logic [7:0] sts0_reg;
  logic [7:0] sts1_reg;
  logic det_en_reg;
  logic auto_reg;
  logic mbh_reg;
  logic shsel_reg;
  logic [7:0] tgt_min_reg;
  logic [7:0] tgt_sec_reg;
  logic [7:0] tgt_blk_reg;
  logic [8:0] last_reg;
  logic rec_reg;
  logic inh_reg;
  logic short_reg;

  // bus state
  logic aw_rdy_reg;
  logic w_rdy_reg;
  logic [`SHSR_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_rdy_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // sector-level decode
  wire mode_buffers, mode_erasure, mode_recdet, mode_discrim;
  wire [7:0] sh_a_file, sh_a_chan, sh_a_subm, sh_a_dtyp;
  wire [3:0] sh_cmp, sh_err;
  wire raw_err_eff, rec_hit, mode_err, mode_bad;
  wire inhibit, is_short, tgt_miss, par_zero;
  wire [7:0] sts0_next, sts1_next, bfflg_next;

  // header bytes are only meaningful in these commands
  assign mode_buffers = (dec_mode == SHSR_WRITE_ONLY) ||
                        (dec_mode == SHSR_REAL_TIME) ||
                        (dec_mode == SHSR_REPEAT);

  assign mode_erasure = (dec_mode == SHSR_MONITOR) ||
                        (dec_mode == SHSR_WRITE_ONLY) ||
                        (dec_mode == SHSR_REAL_TIME);

  assign mode_recdet = (dec_mode == SHSR_MONITOR) ||
                       (dec_mode == SHSR_WRITE_ONLY) ||
                       (dec_mode == SHSR_REAL_TIME) ||
                       (dec_mode == SHSR_ASYNC);

  assign mode_discrim = (dec_mode == SHSR_REAL_TIME) ||
                        (dec_mode == SHSR_REPEAT);

  assign sh_a_file = sector.sh_a[31:24];
  assign sh_a_chan = sector.sh_a[23:16];
  assign sh_a_subm = sector.sh_a[15:8];
  assign sh_a_dtyp = sector.sh_a[7:0];

  // per-byte compare of the two sub-header copies
  assign sh_cmp[3] = sector.sh_a[31:24] != sector.sh_b[31:24];
  assign sh_cmp[2] = sector.sh_a[23:16] != sector.sh_b[23:16];
  assign sh_cmp[1] = sector.sh_a[15:8] != sector.sh_b[15:8];
  assign sh_cmp[0] = sector.sh_a[7:0] != sector.sh_b[7:0];

  assign sh_err = shsel_reg ? sh_cmp
                : (sector.sh_ptr_a & sector.sh_ptr_b);

  assign bfflg_next = {sector.hdr_ptr, sh_err};

  // mode byte handling set: raw mode pointer is disregarded
  assign raw_err_eff = sector.raw_ptr[0] & ~mbh_reg;

  assign rec_hit = det_en_reg && mode_recdet &&
                   ((sector.raw_mode[7:5] != 3'h0) ||
                    raw_err_eff);

  assign mode_err = sector.hdr_ptr[0];
  assign mode_bad = (sector.hdr_mode != `SHSR_MODE1) &&
                    (sector.hdr_mode != `SHSR_MODE2);

  assign inhibit = auto_reg &&
                   (mode_err || mode_bad ||
                    ((sector.hdr_mode == `SHSR_MODE2) &&
                     sector.hdr_ptr[0] == 1'b0 &&
                     sector.sh_ptr_a[1]));

  assign is_short = sector.sync_gap < `SHSR_SHORT_LEN;

  // pointers take no part in the target compare
  assign tgt_miss = (sector.hdr_min != tgt_min_reg) ||
                    (sector.hdr_sec != tgt_sec_reg) ||
                    (sector.hdr_blk != tgt_blk_reg);

  assign par_zero = (sector.parity_ptr == 4'h0) &&
                    (sector.parity == 32'h0);

  assign sts0_next = {
    is_short,
    sector.sync_ins,
    inhibit,
    mode_erasure & sector.any_ptr,
    sector.corrected,
    sector.edc_fail,
    sector.ecc_fail,
    tgt_miss
  };

  // reserved bits 7..3 stay zero
  assign sts1_next = {
    5'h00,
    par_zero,
    mode_discrim & sector.discriminated_mode_bit,
    mode_discrim & sector.discriminated_form_bit
  };

  // per-sector capture on each interrupt; header fields only in buffering commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_mode_reg <= `SHSR_RST_BYTE;
      raw_ptr_reg <= 4'h0;
    end else if (decoder_interrupt) begin
      raw_mode_reg <= sector.raw_mode;
      raw_ptr_reg <= sector.raw_ptr;
    end
  end

  // kept unchanged outside buffering commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_reg <= `SHSR_RST_BYTE;
      mode_reg <= `SHSR_RST_BYTE;
      file_reg <= `SHSR_RST_BYTE;
      chan_reg <= `SHSR_RST_BYTE;
      subm_reg <= `SHSR_RST_BYTE;
      dtyp_reg <= `SHSR_RST_BYTE;
      bfflg_reg <= `SHSR_RST_BYTE;
    end else if (decoder_interrupt && mode_buffers) begin
      blk_reg <= sector.hdr_blk;
      mode_reg <= sector.hdr_mode;
      file_reg <= sh_a_file;
      chan_reg <= sh_a_chan;
      subm_reg <= sh_a_subm;
      dtyp_reg <= sh_a_dtyp;
      bfflg_reg <= bfflg_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts0_reg <= `SHSR_RST_BYTE;
      sts1_reg <= `SHSR_RST_BYTE;
      rec_reg <= 1'b0;
      inh_reg <= 1'b0;
      short_reg <= 1'b0;
    end else if (decoder_interrupt) begin
      sts0_reg <= sts0_next;
      sts1_reg <= sts1_next;
      rec_reg <= rec_hit;
      inh_reg <= inhibit;
      short_reg <= is_short;
    end
  end

  assign correction_inhibit_flag = inh_reg;
  assign short_sector_flag = short_reg;
  assign recordable_disc_status = rec_reg;
  assign last_area = last_reg;

  // write channel
  wire aw_take;
  wire w_take;
  wire do_write;
  wire b_done;
  wire [4:0] wr_idx;
  wire wr_ok;
  wire [7:0] wr_byte;
  wire wr_en;

  assign aw_take = s_axi_awvalid & aw_rdy_reg;
  assign w_take = s_axi_wvalid & w_rdy_reg;
  assign do_write = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
  assign b_done = bvalid_reg & s_axi_bready;
  assign wr_idx = aw_addr_reg[`SHSR_AW-1:2];
  assign wr_byte = w_data_reg[7:0];
  assign wr_en = do_write & w_lane0_reg;

  // read-only registers accept writes silently
  assign wr_ok = (aw_addr_reg[1:0] == 2'h0) &&
                 ((wr_idx == `SHSR_IDX_RAWMODE) ||
                  ((wr_idx >= `SHSR_IDX_BLK) &&
                   (wr_idx <= `SHSR_IDX_LAST_L)) ||
                  ((wr_idx >= `SHSR_IDX_AUX) &&
                   (wr_idx <= `SHSR_IDX_TGT_BLK)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_reg <= 1'b1;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      aw_rdy_reg <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (b_done) begin
      aw_rdy_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_rdy_reg <= 1'b1;
      w_data_reg <= 32'h0;
      w_lane0_reg <= 1'b0;
    end else if (w_take) begin
      w_rdy_reg <= 1'b0;
      w_data_reg <= s_axi_wdata;
      w_lane0_reg <= s_axi_wstrb[0];
    end else if (b_done) begin
      w_rdy_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `SHSR_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? `SHSR_RESP_OKAY : `SHSR_RESP_SLVERR;
    end else if (b_done) begin
      bvalid_reg <= 1'b0;
    end
  end

  // software-owned control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_en_reg <= 1'b0;
      auto_reg <= 1'b0;
      mbh_reg <= 1'b0;
      shsel_reg <= 1'b0;
    end else if (wr_en && wr_idx == `SHSR_IDX_RAWFLG) begin
      det_en_reg <= wr_byte[`SHSR_DET_EN];
    end else if (wr_en && wr_idx == `SHSR_IDX_AUX) begin
      auto_reg <= wr_byte[`SHSR_AUX_AUTO];
      mbh_reg <= wr_byte[`SHSR_AUX_MBH];
      shsel_reg <= wr_byte[`SHSR_AUX_SHSEL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgt_min_reg <= `SHSR_RST_BYTE;
      tgt_sec_reg <= `SHSR_RST_BYTE;
      tgt_blk_reg <= `SHSR_RST_BYTE;
    end else if (wr_en) begin
      if (wr_idx == `SHSR_IDX_TGT_MIN) begin
        tgt_min_reg <= wr_byte;
      end
      if (wr_idx == `SHSR_IDX_TGT_SEC) begin
        tgt_sec_reg <= wr_byte;
      end
      if (wr_idx == `SHSR_IDX_TGT_BLK) begin
        tgt_blk_reg <= wr_byte;
      end
    end
  end

  // high half keeps only bit 8; upper bits read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= 9'h000;
    end else if (wr_en && wr_idx == `SHSR_IDX_LAST_H) begin
      last_reg[8] <= wr_byte[0];
    end else if (wr_en && wr_idx == `SHSR_IDX_LAST_L) begin
      last_reg[7:0] <= wr_byte;
    end
  end

  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = w_rdy_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // read channel
  wire ar_take;
  wire r_done;
  wire [4:0] rd_idx;
  wire rd_aligned;
  wire [7:0] rd_rawflg;
  wire [7:0] rd_aux;
  wire [7:0] rd_byte;
  wire rd_hit;

  assign ar_take = s_axi_arvalid & ar_rdy_reg;
  assign r_done = rvalid_reg & s_axi_rready;
  assign rd_idx = s_axi_araddr[`SHSR_AW-1:2];
  assign rd_aligned = s_axi_araddr[1:0] == 2'h0;

  assign rd_rawflg = {raw_ptr_reg, 3'h0, det_en_reg};
  assign rd_aux = {rec_reg, 4'h0, shsel_reg, mbh_reg, auto_reg};

  assign rd_byte =
    (rd_idx == `SHSR_IDX_RAWMODE) ? raw_mode_reg :
    (rd_idx == `SHSR_IDX_BLK) ? blk_reg :
    (rd_idx == `SHSR_IDX_MODE) ? mode_reg :
    (rd_idx == `SHSR_IDX_FILE) ? file_reg :
    (rd_idx == `SHSR_IDX_CHAN) ? chan_reg :
    (rd_idx == `SHSR_IDX_SUBM) ? subm_reg :
    (rd_idx == `SHSR_IDX_DTYP) ? dtyp_reg :
    (rd_idx == `SHSR_IDX_RAWFLG) ? rd_rawflg :
    (rd_idx == `SHSR_IDX_BFFLG) ? bfflg_reg :
    (rd_idx == `SHSR_IDX_STS0) ? sts0_reg :
    (rd_idx == `SHSR_IDX_STS1) ? sts1_reg :
    (rd_idx == `SHSR_IDX_LAST_H) ? {7'h00, last_reg[8]} :
    (rd_idx == `SHSR_IDX_LAST_L) ? last_reg[7:0] :
    (rd_idx == `SHSR_IDX_AUX) ? rd_aux :
    (rd_idx == `SHSR_IDX_TGT_MIN) ? tgt_min_reg :
    (rd_idx == `SHSR_IDX_TGT_SEC) ? tgt_sec_reg :
    (rd_idx == `SHSR_IDX_TGT_BLK) ? tgt_blk_reg :
    `SHSR_RST_BYTE;

  // 04h and 05h belong to other blocks: unmapped here
  assign rd_hit = rd_aligned &&
                  ((rd_idx == `SHSR_IDX_RAWMODE) ||
                   ((rd_idx >= `SHSR_IDX_BLK) &&
                    (rd_idx <= `SHSR_IDX_LAST_L)) ||
                   ((rd_idx >= `SHSR_IDX_AUX) &&
                    (rd_idx <= `SHSR_IDX_TGT_BLK)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `SHSR_RESP_OKAY;
    end else if (ar_take) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_hit ? {24'h0, rd_byte} : 32'h0;
      rresp_reg <= rd_hit ? `SHSR_RESP_OKAY : `SHSR_RESP_SLVERR;
    end else if (r_done) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : shsr_regs

// ---- verif/shsr_regs_assertions.sv ----
// concurrent checks on the ports of the header/status register bank.
// assumes it is bound into shsr_regs and sees only its ports.
`timescale 1ns/1ps
`include "shsr_map.svh"

module shsr_regs_assertions
  import shsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic decoder_interrupt,
  input wire shsr_dec_mode_t dec_mode,
  input wire shsr_sector_t sector,
  input wire logic correction_inhibit_flag,
  input wire logic short_sector_flag,
  input wire logic recordable_disc_status,
  input wire logic [8:0] last_area,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_read_reserved: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
      s_axi_rresp inside {`SHSR_RESP_OKAY, `SHSR_RESP_SLVERR})
    else $error("read upper bits or response code wrong");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  // area only moves while a write is in flight
  a_area_write: assert property (
    $changed(last_area) |-> !s_axi_awready)
    else $error("last area changed without a write");
  a_short_flag: assert property (
    decoder_interrupt |=>
      short_sector_flag == ($past(sector.sync_gap) < 12'h92f))
    else $error("short sector flag wrong");
  a_rec_mode: assert property (
    decoder_interrupt && dec_mode inside {SHSR_DISABLED, SHSR_REPEAT}
      |=> !recordable_disc_status)
    else $error("recordable status outside detect modes");
  a_rec_nohit: assert property (
    decoder_interrupt && sector.raw_mode[7:5] == 3'h0 &&
      !sector.raw_ptr[0] |=> !recordable_disc_status)
    else $error("recordable status without a condition");
  a_inhibit_ok: assert property (
    decoder_interrupt && sector.hdr_mode == 8'h01 && !sector.hdr_ptr[0]
      |=> !correction_inhibit_flag)
    else $error("inhibit on a clean mode 1 sector");
  a_flags_hold: assert property (
    !decoder_interrupt |=> $stable({short_sector_flag,
      correction_inhibit_flag, recordable_disc_status}))
    else $error("sector flags moved between interrupts");
endmodule : shsr_regs_assertions

bind shsr_regs shsr_regs_assertions u_chk (.aclk, .aresetn,
  .decoder_interrupt, .dec_mode, .sector, .correction_inhibit_flag,
  .short_sector_flag, .recordable_disc_status, .last_area, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);

// ---- verif/shsr_regs_tb.sv ----
// self-checking bench for the sector header/status register bank.
// assumes the bus timing and update rules of the designer's note.
`timescale 1ns/1ps

module shsr_regs_tb;
  import shsr_pkg::*;
  localparam logic [1:0] okay = 2'h0;
  localparam logic [1:0] slverr = 2'h2;
  logic aclk, aresetn, decoder_interrupt;
  shsr_dec_mode_t dec_mode;
  shsr_sector_t sector;
  logic correction_inhibit_flag, short_sector_flag, recordable_disc_status;
  logic [8:0] last_area;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lf;
  logic [3:0] s_axi_wstrb, rawp;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, en, rec, fpend;
  logic [7:0] aux, bfl, st0, st1, rawm, tg[3], hb[6];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [2:0] fq[$];
  int err_total, compares;

  shsr_regs dut (.aclk, .aresetn, .decoder_interrupt, .dec_mode, .sector,
    .correction_inhibit_flag, .short_sector_flag, .recordable_disc_status,
    .last_area, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction : lfsr

  function automatic logic [1:0] okr(input int i);
    return (i == 3 || (i > 5 && i < 18) || (i > 23 && i < 28)) ? okay : slverr;
  endfunction : okr

  task automatic close_out();
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bail();
    chk("handshake", 34'h1, 34'h0);
    close_out();
  endtask : bail

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic s0, input logic [1:0] e);
    bit ta, tw, tb;
    ta = 0;
    tw = 0;
    tb = 0;
    bq.push_back(e);
    lf = lfsr(lf);
    s_axi_awaddr <= a;
    s_axi_wdata <= {lf[31:8], d};
    s_axi_wstrb <= {lf[3:1], s0};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
      // bready stays up: a back-to-back write would else drive it twice
      if (s_axi_bvalid) begin
        tb = 1;
      end
    end
    if (!tb) bail();
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    bit ta, tr;
    ta = 0;
    tr = 0;
    rq.push_back({e, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(posedge aclk);
      if (!ta && s_axi_arready) begin
        ta = 1;
        s_axi_arvalid <= 1'b0;
      end
      // rready stays up: a back-to-back read would else drive it twice
      if (s_axi_rvalid) begin
        tr = 1;
      end
    end
    if (!tr) bail();
  endtask : rd

  task automatic mk(input int k, output shsr_sector_t s);
    logic [191:0] r;
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      r = {r[159:0], lf};
    end
    s = r[174:0];
    if (k % 3 != 2) s.hdr_mode = 8'(k % 3 + 1);
    s.raw_mode = s.hdr_mode;
    s.raw_ptr[0] = s.hdr_ptr[0];
    if (k[2]) {s.hdr_min, s.hdr_sec, s.hdr_blk} = {tg[0], tg[1], tg[2]};
    if (k[0]) s.sync_gap = 12'h92e + 12'(k[1]);
    if (k[1]) {s.parity, s.parity_ptr} = {32'h0, 3'h0, lf[0]};
    if (k[0]) s.sh_b = s.sh_a;
  endtask : mk

  task automatic put(input shsr_dec_mode_t m, input shsr_sector_t s);
    logic inh;
    logic [3:0] sh;
    inh = aux[0] && (s.hdr_ptr[0] || !(s.hdr_mode inside {8'h01, 8'h02}) ||
      (s.hdr_mode == 8'h02 && s.sh_ptr_a[1]));
    rec = en && !(m inside {SHSR_DISABLED, SHSR_REPEAT}) &&
      (s.raw_mode[7:5] != 3'h0 || (!aux[1] && s.raw_ptr[0]));
    for (int i = 0; i < 4; i++)
      sh[i] = aux[2] ? s.sh_a[8*i+:8] != s.sh_b[8*i+:8] :
        s.sh_ptr_a[i] && s.sh_ptr_b[i];
    if (m inside {SHSR_WRITE_ONLY, SHSR_REAL_TIME, SHSR_REPEAT}) begin
      hb = '{s.hdr_blk, s.hdr_mode, s.sh_a[31:24], s.sh_a[23:16],
        s.sh_a[15:8], s.sh_a[7:0]};
      bfl = {s.hdr_ptr, sh};
    end
    rawm = s.raw_mode;
    rawp = s.raw_ptr;
    st0 = {s.sync_gap < 12'h92f, s.sync_ins, inh,
      m inside {SHSR_MONITOR, SHSR_WRITE_ONLY, SHSR_REAL_TIME} && s.any_ptr,
      s.corrected, s.edc_fail, s.ecc_fail,
      {s.hdr_min, s.hdr_sec, s.hdr_blk} != {tg[0], tg[1], tg[2]}};
    st1 = {5'h0, s.parity == 32'h0 && s.parity_ptr == 4'h0,
      m inside {SHSR_REAL_TIME, SHSR_REPEAT} && s.discriminated_mode_bit,
      m inside {SHSR_REAL_TIME, SHSR_REPEAT} && s.discriminated_form_bit};
    fq.push_back({st0[7], inh, rec});
    dec_mode <= m;
    sector <= s;
    decoder_interrupt <= 1'b1;
    @(posedge aclk);
    decoder_interrupt <= 1'b0;
    @(posedge aclk);
  endtask : put

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    if (fpend)
      chk("flags", {31'h0, fq.pop_front()}, {31'h0, short_sector_flag,
        correction_inhibit_flag, recordable_disc_status});
    fpend = decoder_interrupt;
  end

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    shsr_sector_t s;
    {aresetn, decoder_interrupt, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, en, rec} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, sector} = '0;
    {aux, bfl, st0, st1, rawm, rawp} = '0;
    tg = '{default: 8'h00};
    hb = '{default: 8'h00};
    dec_mode = SHSR_DISABLED;
    err_total = 0;
    compares = 0;
    lf = 32'h7e4aeeb4;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 32; i++) rd(7'(i * 4), 8'h00, okr(i));
    rd(7'h1a, 8'h00, slverr);
    wr(7'h14, 8'h5a, 1'b1, slverr);
    wr(7'h38, 8'hff, 1'b1, okay);
    rd(7'h38, 8'h00, okay);
    wr(7'h40, 8'h01, 1'b1, okay);
    wr(7'h44, 8'ha5, 1'b1, okay);
    wr(7'h44, 8'h5a, 1'b0, okay);
    rd(7'h40, 8'h01, okay);
    rd(7'h44, 8'ha5, okay);
    chk("last_area", 34'h1a5, {25'h0, last_area});
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      tg[i] = lf[7:0];
      wr(7'(100 + i * 4), tg[i], 1'b1, okay);
    end
    for (int j = 0; j < 6; j++) begin
      for (int k = 0; k < 8; k++) begin
        lf = lfsr(lf);
        aux = {5'h0, lf[2:0]};
        en = lf[3];
        wr(7'h60, aux, 1'b1, okay);
        wr(7'h30, {7'h0, en}, 1'b1, okay);
        mk(k, s);
        put(shsr_dec_mode_t'(j), s);
        rd(7'h0c, rawm, okay);
        // header bytes only trusted in buffering modes
        if (j inside {2, 3, 4})
          for (int i = 0; i < 6; i++)
            rd(7'(24 + i * 4), hb[i], okay);
        rd(7'h30, {rawp, 3'h0, en}, okay);
        rd(7'h34, bfl, okay);
        rd(7'h38, st0, okay);
        rd(7'h3c, st1, okay);
        rd(7'h60, {rec, 4'h0, aux[2:0]}, okay);
      end
    end
    close_out();
  end
endmodule : shsr_regs_tb
